// ==== rtl/pacs_top.sv ====
// channel sequencer for a shared pipelined converter, AHB-Lite slave
// Overview of operation
// [R1] twelve-stage pipeline, one bit per stage
// [R2] four virtual channels share one pipeline
// [R3] pipelined mode: new sample every clock; here a shorter-latency sample waits rather than overtake
// [R4] non-pipelined: wait until previous conversion completes
// [R5] latency seven clocks 12-bit, five 8-bit
// [R6] gain adds one clock when pipelined
// [R7] first stage MSB, next stage next bit
// [R8] per-channel select, control, result pair registers
// [R9] non-pipelined gain adds one, two, three
// [R10] software avoids mode changes with samples inflight
// [R11] signedness is global; differential forces signed
// [R12] tag channel, write its result, keep order
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "pacs_map.svh"
module pacs_top #(
  parameter int NCH = 4,
  parameter int STAGES = 12,
  parameter int SW = 12
) (
  // clock, reset, clock enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // analogue front end
  input wire logic [11:0] adc_sample,
  output pacs_pkg::pacs_fe_t fe,
  // result stream
  output logic res_valid,
  input wire logic res_ready,
  output pacs_pkg::pacs_res_t res_data
);
  if (NCH != 4 || STAGES < 11 || SW != 12) begin : g_bad
    $error("pacs_top: NCH must be 4, STAGES >= 11, SW 12");
  end

  // bus read state
  typedef enum logic [0:0] {
    PACS_IDLE = 1'b0,
    PACS_RDW = 1'b1
  } pacs_bus_st_t;

  // latency of one sample from its settings
  function automatic logic [3:0] lat_of(input logic res8, input logic pipe,
      input logic [1:0] mode, input logic [2:0] fac);
    logic [3:0] l;
    l = res8 ? `PACS_LAT8 : `PACS_LAT12; // R5
    if (mode == pacs_pkg::PACS_DIFF_GAIN) begin
      if (pipe) begin
        l = l + `PACS_GAIN_PIPE; // R6
      end else if (fac <= `PACS_FAC_4X) begin
        l = l + `PACS_GAIN_LO; // R9
      end else if (fac <= `PACS_FAC_16X) begin
        l = l + `PACS_GAIN_MID; // R9
      end else begin
        l = l + `PACS_GAIN_HI; // R9
      end
    end
    return l;
  endfunction

  // lowest set bit of a request vector
  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] c;
    c = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        c = 2'(i);
      end
    end
    return c;
  endfunction

  // registers
  logic [3:0] ctrl_r; // enable, pipelined, signed, 8-bit
  logic [3:0] pend_r; // start requests not yet issued
  logic [3:0] new_r; // result written since last high-byte read
  logic [7:0] sel_r [NCH]; // channel_input_select per channel
  logic [4:0] cctl_r [NCH]; // mode and amplification_factor
  logic [3:0] rem_r; // edges until the youngest sample completes
  logic [3:0] cnt_r; // samples in flight
  logic [11:0] s1_r, s2_r; // sample synchroniser
  pacs_pkg::pacs_entry_t pipe_r [STAGES]; // conversion stages
  // bus state
  pacs_bus_st_t bst_r;
  logic wr_pend_r; // write data phase pending
  logic [7:0] wa_r; // latched write address
  logic [7:0] ra_r; // latched read address
  // decode and datapath
  logic any_diff, eff_sgn, adv, issue, done_any;
  logic [1:0] ich, dch;
  logic [3:0] ilat;
  logic [15:0] dword, mem_rd;
  logic buf_rdy, ap, ap_rd, ap_wr;
  logic [STAGES-1:0] done_v;
  logic [3:0] start_w;

  // global signedness: any differential channel forces signed
  always_comb begin
    any_diff = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (cctl_r[c][1:0] == pacs_pkg::PACS_DIFF ||
          cctl_r[c][1:0] == pacs_pkg::PACS_DIFF_GAIN) begin
        any_diff = 1'b1;
      end
    end
    eff_sgn = ctrl_r[`PACS_CTRL_SIGN] | any_diff; // R11
  end

  // sample pins cross into the converter clock through two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (ce) begin
      s1_r <= adc_sample;
      s2_r <= s1_r;
    end
  end

  // completion: a sample is done in stage s when its latency is s+1
  for (genvar s = 0; s < STAGES; s++) begin : g_done
    assign done_v[s] = pipe_r[s].valid && pipe_r[s].lat == 4'(s + 1);
  end
  assign done_any = |done_v; // order keeps at most one done at a time

  // pick the done stage and format its word
  always_comb begin
    pacs_pkg::pacs_entry_t e;
    logic [11:0] v;
    e = '0;
    v = 12'h000;
    for (int s = 0; s < STAGES; s++) begin
      if (done_v[s]) begin
        e = pipe_r[s];
      end
    end
    dch = e.chan; // R12
    // resolved upper bits plus the residue of the held sample
    v = e.part | e.samp;
    if (e.res8) begin
      dword = e.sgn ? {{8{v[11]}}, v[11:4]} : {8'h00, v[11:4]};
    end else begin
      dword = e.sgn ? {{4{v[11]}}, v} : {4'h0, v};
    end
  end

  // a finished word the buffer cannot take freezes the whole pipeline
  assign adv = ce && !(done_any && !buf_rdy);

  // issue decision
  assign ich = first_set(pend_r);
  assign ilat = lat_of(ctrl_r[`PACS_CTRL_RES8], ctrl_r[`PACS_CTRL_PIPE],
                       cctl_r[ich][1:0], cctl_r[ich][4:2]);
  always_comb begin
    issue = adv && ctrl_r[`PACS_CTRL_EN] && (pend_r != 4'h0);
    if (ctrl_r[`PACS_CTRL_PIPE]) begin
      // R3: back to back, unless it would overtake the sample before
      // equal latency may follow one edge behind; shorter must wait
      issue = issue && (ilat >= rem_r); // R3 R12
    end else begin
      issue = issue && (cnt_r == 4'h0); // R4
    end
  end

  // stage 0 takes the new sample and resolves its MSB
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pipe_r[0] <= '0;
    end else if (adv) begin
      pipe_r[0].valid <= issue;
      pipe_r[0].chan <= ich; // R12
      pipe_r[0].lat <= ilat;
      pipe_r[0].res8 <= ctrl_r[`PACS_CTRL_RES8];
      pipe_r[0].sgn <= eff_sgn;
      pipe_r[0].samp <= {1'b0, s2_r[10:0]};
      pipe_r[0].part <= {s2_r[11], 11'h000}; // R7
    end
  end

  // later stages each resolve one more bit as the samples shift on
  for (genvar s = 1; s < STAGES; s++) begin : g_stage
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pipe_r[s] <= '0;
      end else if (adv) begin
        // R1, R7
        pipe_r[s].valid <= pipe_r[s-1].valid & ~done_v[s-1];
        pipe_r[s].chan <= pipe_r[s-1].chan;
        pipe_r[s].lat <= pipe_r[s-1].lat;
        pipe_r[s].res8 <= pipe_r[s-1].res8;
        pipe_r[s].sgn <= pipe_r[s-1].sgn;
        pipe_r[s].part <= pipe_r[s-1].part | (pipe_r[s-1].samp &
                          (12'h800 >> s));
        pipe_r[s].samp <= pipe_r[s-1].samp & ~(12'h800 >> s);
      end
    end
  end

  // in-flight count and ordering horizon
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
      rem_r <= 4'h0;
    end else if (adv) begin
      cnt_r <= cnt_r + 4'(issue) - 4'(done_any); // R4
      if (issue) begin
        rem_r <= ilat; // R12
      end else if (rem_r != 4'h0) begin
        rem_r <= rem_r - 4'h1;
      end
    end
  end

  // front-end controls for the sample just issued
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fe <= '0;
    end else if (ce) begin
      fe.strobe <= issue;
      if (issue) begin
        fe.pos <= sel_r[ich][3:0]; // R2
        fe.neg <= sel_r[ich][7:4];
        fe.gain_en <= cctl_r[ich][1:0] == pacs_pkg::PACS_DIFF_GAIN;
        fe.amplification_factor <= cctl_r[ich][4:2];
      end
    end
  end

  // result words leave through the two-entry buffer
  pacs_buf2 #(.W(18)) u_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .in_valid(done_any && ce),
    .in_ready(buf_rdy),
    .in_data({dch, dword}),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  // address phase decode
  assign ap = hsel && htrans[1] && hready;
  assign ap_rd = ap && !hwrite;
  assign ap_wr = ap && hwrite;

  // per-channel result pair store
  pacs_res_mem #(.NCH(NCH), .AW(2)) u_mem (
    .hclk(hclk),
    .ce(ce),
    .we(adv && done_any), // R8, R12
    .waddr(dch),
    .wdata(dword),
    .re(ap_rd),
    .raddr(haddr[5:4]),
    .rdata(mem_rd)
  );

  // write data phase follows the address phase by one edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
    end else if (ce) begin
      wr_pend_r <= ap_wr;
      if (ap_wr) begin
        wa_r <= haddr[7:0];
      end
    end
  end
  assign start_w = (wr_pend_r && wa_r == `PACS_CTRL_OFS) ?
                   hwdata[`PACS_CTRL_START +: 4] : 4'h0;

  // control register and start requests; a new start beats the issue
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `PACS_CTRL_RST;
      pend_r <= 4'h0;
    end else if (ce) begin
      if (wr_pend_r && wa_r == `PACS_CTRL_OFS) begin
        ctrl_r <= hwdata[3:0];
      end
      for (int c = 0; c < NCH; c++) begin
        if (start_w[c]) begin
          pend_r[c] <= 1'b1;
        end else if (issue && ich == 2'(c)) begin
          pend_r[c] <= 1'b0;
        end
      end
    end
  end

  // channel registers: one block per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sel_r[c] <= 8'h00;
        cctl_r[c] <= 5'h02 << `PACS_CTL_MODE;
      end else if (ce && wr_pend_r && wa_r[7:6] == `PACS_CH_TAG &&
                   wa_r[5:4] == 2'(c)) begin
        // R8
        if (wa_r[3:2] == `PACS_CH_MUX) begin
          sel_r[c] <= hwdata[7:0];
        end
        if (wa_r[3:2] == `PACS_CH_CTL) begin
          cctl_r[c] <= hwdata[4:0];
        end
      end
    end
    // new-result flag: a completion beats the clear by a read
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        new_r[c] <= 1'b0;
      end else if (ce) begin
        if (adv && done_any && dch == 2'(c)) begin
          new_r[c] <= 1'b1;
        end else if (bst_r == PACS_RDW && ra_r[7:6] == `PACS_CH_TAG &&
                     ra_r[5:4] == 2'(c) && ra_r[3:2] == `PACS_CH_RESULT_HIGH_BYTE) begin
          new_r[c] <= 1'b0;
        end
      end
    end
  end

  // reads take one wait state so the answer comes from a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bst_r <= PACS_IDLE;
      ra_r <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0; // always OKAY
      unique case (bst_r)
        PACS_IDLE: begin
          if (ap_rd) begin
            bst_r <= PACS_RDW;
            ra_r <= haddr[7:0];
            hreadyout <= 1'b0;
          end
        end
        PACS_RDW: begin
          bst_r <= PACS_IDLE;
          hreadyout <= 1'b1;
          hrdata <= 32'h0000_0000; // unmapped reads as zero
          if (ra_r == `PACS_CTRL_OFS) begin
            hrdata[3:0] <= ctrl_r;
          end else if (ra_r == `PACS_STAT_OFS) begin
            hrdata[3:0] <= pend_r;
            hrdata[`PACS_STAT_NEW +: 4] <= new_r;
            hrdata[`PACS_STAT_BUSY] <= cnt_r != 4'h0;
            hrdata[`PACS_STAT_SIGNED] <= eff_sgn;
          end else if (ra_r[7:6] == `PACS_CH_TAG) begin
            unique case (ra_r[3:2])
              `PACS_CH_MUX: hrdata[7:0] <= sel_r[ra_r[5:4]];
              `PACS_CH_CTL: hrdata[4:0] <= cctl_r[ra_r[5:4]];
              `PACS_CH_RESULT_LOW_BYTE: hrdata[7:0] <= mem_rd[7:0];
              `PACS_CH_RESULT_HIGH_BYTE: hrdata[7:0] <= mem_rd[15:8];
            endcase
          end
        end
      endcase
    end
  end
endmodule // pacs_top

// ==== common/pacs_map.svh ====
// register offsets, field positions, reset values and latency counts
`ifndef PACS_MAP_SVH
`define PACS_MAP_SVH
// byte addresses on the register bus
`define PACS_CTRL_OFS 8'h00
`define PACS_STAT_OFS 8'h04
`define PACS_CH_TAG 2'b01
// word select inside a channel block at 0x40 + ch*0x10
`define PACS_CH_MUX 2'h0
`define PACS_CH_CTL 2'h1
`define PACS_CH_RESULT_LOW_BYTE 2'h2
`define PACS_CH_RESULT_HIGH_BYTE 2'h3
// control register fields
`define PACS_CTRL_EN 0
`define PACS_CTRL_PIPE 1
`define PACS_CTRL_SIGN 2
`define PACS_CTRL_RES8 3
`define PACS_CTRL_START 4
`define PACS_CTRL_RST 4'h2
// status register fields
`define PACS_STAT_NEW 4
`define PACS_STAT_BUSY 8
`define PACS_STAT_SIGNED 9
// channel control fields
`define PACS_CTL_MODE 0
`define PACS_CTL_FAC 2
// latency counts in converter clocks
`define PACS_LAT12 4'd7
`define PACS_LAT8 4'd5
`define PACS_GAIN_PIPE 4'd1
`define PACS_GAIN_LO 4'd1
`define PACS_GAIN_MID 4'd2
`define PACS_GAIN_HI 4'd3
// gain codes: 0=1x 1=2x 2=4x 3=8x 4=16x 5=32x 6=64x
`define PACS_FAC_4X 3'd2
`define PACS_FAC_16X 3'd4
`endif

// ==== common/pacs_pkg.sv ====
// types shared by the channel sequencer modules
package pacs_pkg;
  // channel input mode
  typedef enum logic [1:0] {
    PACS_DIFF = 2'b00,
    PACS_DIFF_GAIN = 2'b01,
    PACS_SINGLE = 2'b10,
    PACS_INTERNAL = 2'b11
  } pacs_mode_t;
  // one sample in flight through the conversion pipeline
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [3:0] lat;
    logic res8;
    logic sgn;
    logic [11:0] samp;
    logic [11:0] part;
  } pacs_entry_t;
  // finished result tagged with its channel
  typedef struct packed {
    logic [1:0] chan;
    logic [15:0] data;
  } pacs_res_t;
  // controls toward the analogue multiplexers and gain stage
  typedef struct packed {
    logic strobe;
    logic [3:0] pos;
    logic [3:0] neg;
    logic gain_en;
    logic [2:0] amplification_factor;
  } pacs_fe_t;
endpackage

// ==== rtl/pacs_buf2.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pacs_buf2 #(
  parameter int W = 18
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic v1_r; // second slot holds a word
  logic [W-1:0] d1_r; // second slot data
  logic push, pop;
  assign in_ready = ~v1_r; // full only when both slots hold words
  assign push = in_valid & ~v1_r;
  assign pop = out_valid & out_ready;
  // head slot drives the outputs straight from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      v1_r <= 1'b0;
      out_data <= '0;
      d1_r <= '0;
    end else if (ce) begin
      if (pop) begin
        // head leaves: second slot moves up, or with the second slot empty a new word goes straight to the head
        out_valid <= v1_r | push;
        out_data <= v1_r ? d1_r : in_data;
        v1_r <= v1_r & push;
        d1_r <= in_data;
      end else if (push) begin
        if (!out_valid) begin
          out_valid <= 1'b1;
          out_data <= in_data;
        end else begin
          v1_r <= 1'b1;
          d1_r <= in_data;
        end
      end
    end
  end
endmodule // pacs_buf2

// ==== rtl/pacs_res_mem.sv ====
// result word store, one 16-bit word per channel, registered read
`timescale 1ns/1ps
module pacs_res_mem #(
  parameter int NCH = 4,
  parameter int AW = 2
) (
  // clock
  input wire logic hclk,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata,
  // read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [NCH]; // result words
  // storage has no reset; software sees a defined word only after a conversion
  always_ff @(posedge hclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end
  // read data leave through a register
  always_ff @(posedge hclk) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule // pacs_res_mem

// ==== sim/pacs_fe_model.sv ====
// behavioural model of the analogue input multiplexers and gain stage
`timescale 1ns/1ps
module pacs_fe_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // controls from the sequencer
  input wire pacs_pkg::pacs_fe_t fe,
  // analogue level chosen by the bench
  input wire logic [11:0] level,
  // raw value toward the converter
  output logic [11:0] adc_sample,
  output logic [3:0] strobe_cnt
);
  // settles one clock after a level change, like a slow front end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_sample <= 12'h000;
    end else begin
      adc_sample <= level;
    end
  end
  // count issued samples so a stuck strobe shows up in waves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_cnt <= 4'h0;
    end else if (fe.strobe) begin
      strobe_cnt <= strobe_cnt + 4'h1;
    end
  end
endmodule // pacs_fe_model

// ==== sim/pacs_top_assertions.sv ====
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module pacs_chk #(
  parameter int NCH = 4,
  parameter int STAGES = 12,
  parameter int SW = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [11:0] adc_sample,
  input wire pacs_pkg::pacs_fe_t fe,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire pacs_pkg::pacs_res_t res_data
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] inflight_r; // strobes seen but results not yet taken
  logic take; // address phase accepted
  assign take = hsel && htrans[1] && hready && ce;
  // issued minus delivered; a result without a sample is a tagging bug
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inflight_r <= 4'h0;
    end else begin
      inflight_r <= inflight_r + {3'h0, fe.strobe}
        - {3'h0, res_valid && res_ready};
    end
  end
  rd_wait_a: assert property (take && !hwrite && hreadyout |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  wr_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response");
  rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved");
  res_hold_a: assert property (res_valid && !res_ready |=>
    res_valid && $stable(res_data)) else $error("result dropped");
  res_cause_a: assert property (res_valid && res_ready |->
    inflight_r != 4'h0) else $error("result without sample");
  fe_hold_a: assert property ($changed({fe.pos, fe.neg, fe.gain_en,
    fe.amplification_factor}) |-> fe.strobe) else $error("select moved");
  lat_window_a: assert property (fe.strobe && inflight_r == 4'h0 &&
    !res_valid |-> !res_valid [*5] ##[1:6] res_valid)
    else $error("latency out of range");
  cover property (fe.strobe && res_valid);
  cover property (res_valid && !res_ready);
  cover property ($fell(hreadyout));
endmodule // pacs_chk
bind pacs_top pacs_chk #(.NCH(NCH), .STAGES(STAGES), .SW(SW)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .adc_sample(adc_sample), .fe(fe), .res_valid(res_valid),
  .res_ready(res_ready), .res_data(res_data));

// ==== sim/tb.sv ====
// self-checking bench for the channel sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module tb;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic res_valid, res_ready;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [11:0] adc_sample, level;
  pacs_pkg::pacs_fe_t fe;
  pacs_pkg::pacs_res_t res_data;
  int errors, samples_checked, cyc;
  int st_cyc[$];
  int rs_cyc[$];
  logic [11:0] fe_q[$]; // factor, gain enable, neg and pos per issue
  pacs_pkg::pacs_res_t res_q[$];
  assign hready = hreadyout; // single slave
  pacs_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .adc_sample(adc_sample), .fe(fe),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  pacs_fe_model u_fe (.hclk(hclk), .hresetn(hresetn), .fe(fe),
    .level(level), .adc_sample(adc_sample), .strobe_cnt());
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic end_of_test();
    $display("errors=%0d checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // record issues and delivered results, and cut a hang short
  always @(posedge hclk) begin
    cyc++;
    if (fe.strobe === 1'b1) begin
      st_cyc.push_back(cyc);
      fe_q.push_back({fe.amplification_factor, fe.gain_en, fe.neg,
                      fe.pos});
    end
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      rs_cyc.push_back(cyc);
      res_q.push_back(res_data);
    end
    if (cyc > 20000) begin
      errors++;
      end_of_test();
    end
  end
  // one single transfer; holds each phase until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic clear();
    st_cyc.delete();
    rs_cyc.delete();
    fe_q.delete();
    res_q.delete();
  endtask
  // bounded wait for n delivered results
  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (res_q.size() < n && k < 300) begin
      @(posedge hclk);
      k++;
    end
    `CHK(res_q.size(), n);
  endtask
  // reset values of all four channel blocks and an unmapped word
  task automatic s_reset();
    bus(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h2);
    for (int c = 0; c < 4; c++) begin
      bus(1'b0, 8'h40 + 8'(c * 16), 32'h0);
      `CHK(rd, 32'h0);
      bus(1'b0, 8'h44 + 8'(c * 16), 32'h0);
      `CHK(rd, 32'h2);
    end
    bus(1'b1, 8'h24, 32'hffffffff);
    bus(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'h0);
  endtask
  // latency of every resolution, gain and variant on channel 0
  task automatic s_latency();
    logic [7:0] cv[8] = '{8'h03, 8'h0b, 8'h03, 8'h01, 8'h01, 8'h01,
                          8'h01, 8'h03};
    logic [7:0] kv[8] = '{8'h02, 8'h02, 8'h01, 8'h09, 8'h0d, 8'h19,
                          8'h02, 8'h00};
    int lv[8] = '{7, 5, 8, 8, 9, 10, 7, 7};
    for (int i = 0; i < 8; i++) begin
      // each case starts only after the previous result drained
      clear();
      bus(1'b1, 8'h44, {24'h0, kv[i]});
      bus(1'b1, 8'h00, {24'h0, cv[i] | 8'h10});
      wait_res(1);
      `CHK(rs_cyc[0] - st_cyc[0], lv[i]);
      `CHK(fe_q[0][8], kv[i][1:0] == 2'b01);
      `CHK(fe_q[0][11:9], kv[i][4:2]);
      bus(1'b0, 8'h04, 32'h0);
      `CHK(rd[9], kv[i][1] == 1'b0);
      `CHK(rd[8], 1'b0);
      `CHK(rd[4], 1'b1);
      `CHK(res_q[0].data, cv[i][3] ? 16'h005a : 16'h05a3);
      if (!cv[i][3]) begin
        bus(1'b0, 8'h48, 32'h0);
        `CHK(rd[7:0], 8'ha3);
        bus(1'b0, 8'h4c, 32'h0);
        `CHK(rd[7:0], 8'h05);
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd[4], 1'b0);
      end
    end
  endtask
  // four channels back to back while the consumer stalls
  task automatic s_pipe();
    clear();
    res_ready <= 1'b0;
    bus(1'b1, 8'h44, 32'h2);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h40 + 8'(c * 16), {24'h0, 4'(c), 4'(c + 4)});
    end
    bus(1'b1, 8'h00, 32'hf3);
    repeat (20) @(posedge hclk);
    `CHK(st_cyc.size(), 4);
    `CHK(st_cyc[3] - st_cyc[0], 3);
    `CHK(res_valid, 1'b1);
    res_ready <= 1'b1;
    wait_res(4);
    for (int k = 0; k < 4; k++) begin
      `CHK(res_q[k].chan, 2'(k));
      `CHK(fe_q[k][3:0], 4'(k + 4));
      `CHK(fe_q[k][7:4], 4'(k));
      `CHK(res_q[k].data, 16'h05a3);
    end
  endtask
  // non-pipelined: second channel waits for the first to finish
  task automatic s_nonpipe();
    int gap;
    clear();
    bus(1'b1, 8'h00, 32'h31);
    wait_res(2);
    gap = st_cyc[1] - st_cyc[0];
    `CHK(gap >= 7 && gap <= 8, 1'b1);
    `CHK(res_q[1].chan, 2'h1);
  endtask
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    res_ready = 1'b1;
    level = 12'h5a3;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_latency();
    s_pipe();
    s_nonpipe();
    end_of_test();
  end
endmodule // tb
